// ==== logic/oabag_defines.vh ====
// Constants for the operand and branch address generator
`ifndef OABAG_DEFINES_VH
`define OABAG_DEFINES_VH

// Operand modes
`define OABAG_OPM_INDIRECT 3'h0
`define OABAG_OPM_AUTOMOD 3'h1
`define OABAG_OPM_DIRECT 3'h2
`define OABAG_OPM_IMMED 3'h3
`define OABAG_OPM_SHORTIMM 3'h4
`define OABAG_OPM_REGWIN 3'h5
`define OABAG_OPM_TABLEDATA 3'h6

// Transfer kinds
`define OABAG_XFR_NONE 3'h0
`define OABAG_XFR_RELATIVE 3'h1
`define OABAG_XFR_ABSOLUTE 3'h2
`define OABAG_XFR_LONG 3'h3
`define OABAG_XFR_TABLE 3'h4
`define OABAG_XFR_VECTOR 3'h5

// Widths, field positions, register window base and reset values
`define OABAG_PC_W 15
`define OABAG_PCL_W 8
`define OABAG_PCH_W 7
`define OABAG_ABS_W 12
`define OABAG_REL_W 6
`define OABAG_REGWIN_BASE 8'hf0
`define OABAG_PSW_CARRY_BIT 0
`define OABAG_PSW_NIBBLE_BIT 1
`define OABAG_PSW_GIE_BIT 2
`define OABAG_PSW_RESET 8'h00
`define OABAG_PC_RESET 15'h0000
`define OABAG_PTR_RESET 8'h00

`endif

// ==== logic/oabag_rel_adder.v ====
// Relative jump target adder across the whole program counter
`default_nettype none

module oabag_rel_adder #(
	parameter PC_W = 15,
	parameter OFF_W = 6
)(
	input wire [PC_W-1:0] pc_i,
	input wire [OFF_W-1:0] offset_i,
	output wire [PC_W-1:0] target_o
);
	wire [PC_W-1:0] ext_offset;

	// Offset is two's complement; extend its sign bit before the add
	assign ext_offset = {{(PC_W-OFF_W){offset_i[OFF_W-1]}}, offset_i};
	// The field counts from the byte after the jump, so six bits span -31 to +32
	// Full-width add: no page limit, carries reach the top bit
	assign target_o = pc_i + ext_offset + {{(PC_W-1){1'b0}}, 1'b1};

endmodule
`default_nettype wire

// ==== logic/oabag_top.v ====
// Operand and branch address generator of an 8-bit core
//
// Functional notes
// - Indirect mode addresses data memory through the selected pointer.
// - Auto-modify load/exchange uses pointer, steps it at the edge that issues the access.
// - Direct mode addresses data memory with an 8-bit instruction field.
// - Immediate mode uses an 8-bit instruction field as operand, no access.
// - Short-pointer load takes its operand from a 4-bit field.
// - Table-data load reads program memory at upper PC with accumulator low.
// - Relative jump adds offset to PC, range -31 to +32.
// - Displacement of plus one is the no-operation, not a jump.
// - Relative addition spans all 15 PC bits, no page wrap.
// - Absolute jump/call replace only the low 12 PC bits.
// - Long jump/call load all 15 PC bits from the field.
// - Table jump reads byte at accumulator address, loads it into PC low.
// - Vectored interrupt loads PC from a two-byte vector in program memory.
// - PC is 15 bits: 7-bit high part and 8-bit low part.
// - Stack pointer, accumulator and both pointers are 8 bits.
// - Register window operands address F0 through FF.
// - Flags word holds carry, nibble overflow and global irq enable.
`default_nettype none
`include "oabag_defines.vh"

module oabag_top #(
	parameter PC_W = `OABAG_PC_W,
	parameter OFF_W = `OABAG_REL_W
)(
	input wire clk_i,
	input wire reset_i,
	// Decode side
	input wire op_valid_i,
	input wire [2:0] operand_mode_i,
	input wire ptr_sel_i,
	input wire ptr_dec_i,
	input wire [7:0] field8_i,
	input wire [3:0] field4_i,
	input wire [3:0] regwin_idx_i,
	input wire [2:0] xfer_kind_i,
	input wire [OFF_W-1:0] rel_offset_i,
	input wire [11:0] abs_field_i,
	input wire [14:0] long_field_i,
	input wire [14:0] vector_addr_i,
	input wire [7:0] accumulator_i,
	input wire [7:0] stack_pointer_i,
	input wire ptr_wr_i,
	input wire ptr_wr_sel_i,
	input wire [7:0] ptr_wr_data_i,
	input wire flags_wr_i,
	input wire [7:0] flags_wr_data_i,
	// Program memory read data
	input wire [7:0] prog_rdata_i,
	// Data memory, immediate and program memory outputs
	output reg dmem_req_o,
	output reg [7:0] dmem_addr_o,
	output reg imm_valid_o,
	output reg [7:0] imm_operand_o,
	output reg prog_req_o,
	output reg [PC_W-1:0] prog_addr_o,
	output reg [7:0] prog_data_o,
	output reg prog_data_valid_o,
	// Architectural state and busy status
	output reg [PC_W-1:0] program_counter_o,
	output reg [7:0] ptr_b_o,
	output reg [7:0] ptr_x_o,
	output reg [7:0] stack_pointer_o,
	output reg [7:0] processor_flags_word_o,
	output reg busy_o
);
	// =====================================================================
	// States
	// =====================================================================
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_TBL = 4'b0010;
	localparam [3:0] ST_VEC_HI = 4'b0100;
	localparam [3:0] ST_VEC_LO = 4'b1000;

	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg [7:0] vector_high_byte_r;
	reg [7:0] vector_high_byte_nxt;
	reg [PC_W-1:0] pc_nxt;
	reg [7:0] ptr_b_nxt;
	reg [7:0] ptr_x_nxt;
	reg dmem_req_nxt;
	reg [7:0] dmem_addr_nxt;
	reg imm_valid_nxt;
	reg [7:0] imm_nxt;
	reg prog_req_nxt;
	reg [PC_W-1:0] prog_addr_nxt;
	reg prog_data_valid_nxt;
	reg [7:0] prog_data_nxt;
	reg table_data_r;
	reg table_data_nxt;
	reg [7:0] flags_nxt;

	wire [PC_W-1:0] rel_target;
	wire [7:0] sel_ptr;
	wire [PC_W-1:0] pc_seq;
	wire rel_is_nop;

	// =====================================================================
	// Helpers
	// =====================================================================
	// Program address with the accumulator in the low byte
	function [PC_W-1:0] acc_addr;
		input [PC_W-1:0] pc;
		input [7:0] acc;
		begin
			acc_addr = {pc[PC_W-1:`OABAG_PCL_W], acc};
		end
	endfunction

	// Modulo-256 pointer step
	function [7:0] ptr_step;
		input [7:0] ptr;
		input dec;
		begin
			if (dec)
				ptr_step = ptr - 8'h01;
			else
				ptr_step = ptr + 8'h01;
		end
	endfunction

	oabag_rel_adder #(
		.PC_W(PC_W),
		.OFF_W(OFF_W)
	) u_rel (
		.pc_i(program_counter_o),
		.offset_i(rel_offset_i),
		.target_o(rel_target)
	);

	assign sel_ptr = ptr_sel_i ? ptr_x_o : ptr_b_o;
	assign pc_seq = program_counter_o + {{(PC_W-1){1'b0}}, 1'b1};
	// A zero field is displacement +1, the NOP encoding; it falls through
	assign rel_is_nop = (rel_offset_i == {OFF_W{1'b0}});

	// =====================================================================
	// Next-state logic
	// =====================================================================
	always @*
	begin
		state_nxt = state_r;
		vector_high_byte_nxt = vector_high_byte_r;
		pc_nxt = program_counter_o;
		ptr_b_nxt = ptr_b_o;
		ptr_x_nxt = ptr_x_o;
		dmem_req_nxt = 1'b0;
		dmem_addr_nxt = dmem_addr_o;
		imm_valid_nxt = 1'b0;
		imm_nxt = imm_operand_o;
		prog_req_nxt = 1'b0;
		prog_addr_nxt = prog_addr_o;
		prog_data_valid_nxt = 1'b0;
		prog_data_nxt = prog_data_o;
		table_data_nxt = table_data_r;
		flags_nxt = processor_flags_word_o;
		if (flags_wr_i)
			flags_nxt = flags_wr_data_i;
		if (ptr_wr_i)
		begin
			if (ptr_wr_sel_i)
				ptr_x_nxt = ptr_wr_data_i;
			else
				ptr_b_nxt = ptr_wr_data_i;
		end
		case (state_r)
			ST_IDLE:
			begin
				if (op_valid_i)
				begin
					case (operand_mode_i)
						`OABAG_OPM_INDIRECT:
						begin
							dmem_req_nxt = 1'b1;
							dmem_addr_nxt = sel_ptr;
						end
						`OABAG_OPM_AUTOMOD:
						begin
							// Access uses the old pointer; the step lands as the op retires
							dmem_req_nxt = 1'b1;
							dmem_addr_nxt = sel_ptr;
							if (ptr_sel_i)
								ptr_x_nxt = ptr_step(ptr_x_o, ptr_dec_i);
							else
								ptr_b_nxt = ptr_step(ptr_b_o, ptr_dec_i);
						end
						`OABAG_OPM_DIRECT:
						begin
							dmem_req_nxt = 1'b1;
							dmem_addr_nxt = field8_i;
						end
						`OABAG_OPM_IMMED:
						begin
							imm_valid_nxt = 1'b1;
							imm_nxt = field8_i;
						end
						`OABAG_OPM_SHORTIMM:
						begin
							imm_valid_nxt = 1'b1;
							imm_nxt = {4'h0, field4_i};
						end
						`OABAG_OPM_REGWIN:
						begin
							dmem_req_nxt = 1'b1;
							dmem_addr_nxt = `OABAG_REGWIN_BASE | {4'h0, regwin_idx_i};
						end
						`OABAG_OPM_TABLEDATA:
						begin
							prog_req_nxt = 1'b1;
							prog_addr_nxt = acc_addr(program_counter_o, accumulator_i);
							table_data_nxt = 1'b1;
							state_nxt = ST_TBL;
						end
						default:
						begin
							dmem_req_nxt = 1'b0;
						end
					endcase
					case (xfer_kind_i)
						`OABAG_XFR_RELATIVE:
						begin
							if (rel_is_nop)
								pc_nxt = pc_seq;
							else
								pc_nxt = rel_target;
						end
						`OABAG_XFR_ABSOLUTE:
						begin
							pc_nxt = {program_counter_o[PC_W-1:`OABAG_ABS_W], abs_field_i};
						end
						`OABAG_XFR_LONG:
						begin
							pc_nxt = long_field_i;
						end
						`OABAG_XFR_TABLE:
						begin
							prog_req_nxt = 1'b1;
							prog_addr_nxt = acc_addr(program_counter_o, accumulator_i);
							table_data_nxt = 1'b0;
							state_nxt = ST_TBL;
						end
						`OABAG_XFR_VECTOR:
						begin
							// High byte first, then the adjacent low byte
							prog_req_nxt = 1'b1;
							prog_addr_nxt = vector_addr_i;
							state_nxt = ST_VEC_HI;
						end
						default:
						begin
							pc_nxt = program_counter_o;
						end
					endcase
				end
			end
			ST_TBL:
			begin
				// Memory answers in the same cycle as the registered request
				if (table_data_r)
				begin
					prog_data_valid_nxt = 1'b1;
					prog_data_nxt = prog_rdata_i;
				end
				else
				begin
					pc_nxt = {program_counter_o[PC_W-1:`OABAG_PCL_W], prog_rdata_i};
				end
				state_nxt = ST_IDLE;
			end
			ST_VEC_HI:
			begin
				vector_high_byte_nxt = prog_rdata_i;
				prog_req_nxt = 1'b1;
				prog_addr_nxt = prog_addr_o + {{(PC_W-1){1'b0}}, 1'b1};
				state_nxt = ST_VEC_LO;
			end
			ST_VEC_LO:
			begin
				// Top bit of the high byte is dropped: PC is only 15 bits wide
				pc_nxt = {vector_high_byte_r[`OABAG_PCH_W-1:0], prog_rdata_i};
				state_nxt = ST_IDLE;
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// =====================================================================
	// Registers
	// =====================================================================
	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			state_r <= ST_IDLE;
			vector_high_byte_r <= 8'h00;
			table_data_r <= 1'b0;
			program_counter_o <= `OABAG_PC_RESET;
			ptr_b_o <= `OABAG_PTR_RESET;
			ptr_x_o <= `OABAG_PTR_RESET;
			stack_pointer_o <= `OABAG_PTR_RESET;
			processor_flags_word_o <= `OABAG_PSW_RESET;
			dmem_req_o <= 1'b0;
			dmem_addr_o <= 8'h00;
			imm_valid_o <= 1'b0;
			imm_operand_o <= 8'h00;
			prog_req_o <= 1'b0;
			prog_addr_o <= `OABAG_PC_RESET;
			prog_data_o <= 8'h00;
			prog_data_valid_o <= 1'b0;
			busy_o <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			vector_high_byte_r <= vector_high_byte_nxt;
			table_data_r <= table_data_nxt;
			program_counter_o <= pc_nxt;
			ptr_b_o <= ptr_b_nxt;
			ptr_x_o <= ptr_x_nxt;
			stack_pointer_o <= stack_pointer_i;
			processor_flags_word_o <= flags_nxt;
			dmem_req_o <= dmem_req_nxt;
			dmem_addr_o <= dmem_addr_nxt;
			imm_valid_o <= imm_valid_nxt;
			imm_operand_o <= imm_nxt;
			prog_req_o <= prog_req_nxt;
			prog_addr_o <= prog_addr_nxt;
			prog_data_o <= prog_data_nxt;
			prog_data_valid_o <= prog_data_valid_nxt;
			busy_o <= (state_nxt != ST_IDLE);
		end
	end

endmodule
`default_nettype wire

// ==== test/oabag_monitor.sv ====
// Port checker for the address generator
`default_nettype none
module oabag_monitor (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic op_valid_i,
	input wire logic [2:0] operand_mode_i,
	input wire logic ptr_sel_i,
	input wire logic ptr_dec_i,
	input wire logic [7:0] field8_i,
	input wire logic [3:0] regwin_idx_i,
	input wire logic [2:0] xfer_kind_i,
	input wire logic [5:0] rel_offset_i,
	input wire logic [11:0] abs_field_i,
	input wire logic [14:0] long_field_i,
	input wire logic dmem_req_o,
	input wire logic [7:0] dmem_addr_o,
	input wire logic imm_valid_o,
	input wire logic [7:0] imm_operand_o,
	input wire logic [14:0] program_counter_o,
	input wire logic [7:0] ptr_b_o,
	input wire logic busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire logic tk = op_valid_i && !busy_o;
	// Operand checks only on pure operand ops, a transfer may suppress the access
	wire logic to = tk && xfer_kind_i == 3'h0;
	wire logic [2:0] m = operand_mode_i;
	wire logic [14:0] rel_x = {{9{rel_offset_i[5]}}, rel_offset_i};
	wire logic [14:0] abs_x = {program_counter_o[14:12], abs_field_i};
	// ==========================================
	// Assertions
	ind_addr_a: assert property (to && m == 3'h0 && !ptr_sel_i |=>
		dmem_req_o && dmem_addr_o == $past(ptr_b_o)) else $error("indirect address wrong");
	auto_step_a: assert property (to && m == 3'h1 && !ptr_sel_i && !ptr_dec_i |=>
		dmem_addr_o == $past(ptr_b_o) && ptr_b_o == $past(ptr_b_o) + 8'h01)
		else $error("pointer step wrong");
	dir_addr_a: assert property (to && m == 3'h2 |=>
		dmem_req_o && dmem_addr_o == $past(field8_i)) else $error("direct address wrong");
	imm_op_a: assert property (to && m == 3'h3 |=>
		imm_valid_o && !dmem_req_o && imm_operand_o == $past(field8_i))
		else $error("immediate wrong");
	reg_win_a: assert property (to && m == 3'h5 |=>
		dmem_addr_o == {4'hf, $past(regwin_idx_i)}) else $error("window address wrong");
	// Displacement counts from the byte after the jump, so the reach is -31 to +32
	rel_tgt_a: assert property (tk && xfer_kind_i == 3'h1 |=>
		program_counter_o == $past(program_counter_o) + $past(rel_x) + 15'h0001)
		else $error("relative wrong");
	abs_tgt_a: assert property (tk && xfer_kind_i == 3'h2 |=>
		program_counter_o == $past(abs_x)) else $error("absolute target wrong");
	long_tgt_a: assert property (tk && xfer_kind_i == 3'h3 |=>
		program_counter_o == $past(long_field_i)) else $error("long target wrong");
	cover property (tk && xfer_kind_i == 3'h4);
	cover property (tk && xfer_kind_i == 3'h5);
	cover property (op_valid_i && busy_o);
endmodule
`default_nettype wire

// ==== test/oabag_prog_mem.sv ====
// Program memory model, read data stands in the cycle of the request
`default_nettype none
module oabag_prog_mem (
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic [14:0] addr_i,
	output logic [7:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] idle_r = 8'h00;
	// Between answers the bus toggles so stale data cannot pass as a read
	always @(posedge clk_i)
		idle_r <= ~idle_r;
	// The generator samples at the edge that ends its request cycle
	assign rdata_o = req_i ? (addr_i[7:0] ^ {1'b0, addr_i[14:8]} ^ 8'h5a) : idle_r;
endmodule
`default_nettype wire

// ==== test/oabag_top_test.sv ====
// Self-checking bench for the address generator
`default_nettype none
module oabag_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, reset_i = 1'b1, op_valid_i = 1'b0, ptr_sel_i = 1'b0, ptr_dec_i = 1'b0;
	logic ptr_wr_i = 1'b0, ptr_wr_sel_i = 1'b0, flags_wr_i = 1'b0;
	logic [2:0] operand_mode_i = 3'h0, xfer_kind_i = 3'h0;
	logic [3:0] field4_i = 4'h0, regwin_idx_i = 4'h0;
	logic [5:0] rel_offset_i = 6'h00;
	logic [7:0] field8_i = 8'h00, accumulator_i = 8'h00, stack_pointer_i = 8'h00;
	logic [7:0] ptr_wr_data_i = 8'h00, flags_wr_data_i = 8'h00;
	logic [11:0] abs_field_i = 12'h000;
	logic [14:0] long_field_i = 15'h0000, vector_addr_i = 15'h0000;
	wire logic dmem_req_o, imm_valid_o, prog_req_o, prog_data_valid_o, busy_o;
	wire logic [7:0] prog_rdata_i, dmem_addr_o, imm_operand_o, prog_data_o;
	wire logic [7:0] ptr_b_o, ptr_x_o, stack_pointer_o, processor_flags_word_o;
	wire logic [14:0] prog_addr_o, program_counter_o;
	int num_errors = 0, check_count = 0, cyc = 0;
	oabag_top u_dut (.*);
	oabag_prog_mem u_mem (.clk_i(clk_i), .req_i(prog_req_o), .addr_i(prog_addr_o),
		.rdata_o(prog_rdata_i));
	always #5 clk_i = ~clk_i;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Runs far shorter than this; a hang lands here
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			num_errors++;
			end_sim();
		end
	end
	// Presents one op and looks just after the edge n-1 cycles past the taking edge
	task automatic go(input logic [2:0] m, input logic [2:0] k, input int n);
		@(posedge clk_i);
		operand_mode_i <= m;
		xfer_kind_i <= k;
		op_valid_i <= 1'b1;
		@(posedge clk_i);
		op_valid_i <= 1'b0;
		repeat (n - 1) @(posedge clk_i);
		#1;
	endtask
	task automatic t_state();
		@(posedge clk_i);
		flags_wr_i <= 1'b1;
		flags_wr_data_i <= 8'h07;
		stack_pointer_i <= 8'hc3;
		ptr_wr_i <= 1'b1;
		ptr_wr_data_i <= 8'hff;
		@(posedge clk_i);
		flags_wr_i <= 1'b0;
		ptr_wr_sel_i <= 1'b1;
		ptr_wr_data_i <= 8'h00;
		@(posedge clk_i);
		ptr_wr_i <= 1'b0;
		#1;
		chk(program_counter_o, 15'h0000);
		chk(processor_flags_word_o, 8'h07);
		chk({stack_pointer_o, ptr_b_o}, 16'hc3ff);
	endtask
	task automatic t_operand();
		go(3'h0, 3'h0, 1);
		chk({dmem_req_o, dmem_addr_o}, 9'h1ff);
		go(3'h1, 3'h0, 1);
		chk({dmem_addr_o, ptr_b_o}, 16'hff00);
		@(posedge clk_i);
		ptr_sel_i <= 1'b1;
		ptr_dec_i <= 1'b1;
		field8_i <= 8'h3c;
		field4_i <= 4'h9;
		regwin_idx_i <= 4'hd;
		go(3'h1, 3'h0, 1);
		chk({dmem_addr_o, ptr_x_o}, 16'h00ff);
		go(3'h2, 3'h0, 1);
		chk({dmem_req_o, dmem_addr_o}, 9'h13c);
		go(3'h3, 3'h0, 1);
		chk({imm_valid_o, dmem_req_o, imm_operand_o}, 10'h23c);
		go(3'h4, 3'h0, 1);
		chk({imm_valid_o, imm_operand_o}, 9'h109);
		go(3'h5, 3'h0, 1);
		chk(dmem_addr_o, 8'hfd);
	endtask
	task automatic t_jump();
		@(posedge clk_i);
		long_field_i <= 15'h50fe;
		rel_offset_i <= 6'h1f;
		abs_field_i <= 12'h123;
		go(3'h0, 3'h3, 1);
		chk(program_counter_o, 15'h50fe);
		// Field counts from the next byte: +31 reaches +32 and crosses a page
		go(3'h0, 3'h1, 1);
		chk(program_counter_o, 15'h511e);
		@(posedge clk_i);
		rel_offset_i <= 6'h20;
		go(3'h0, 3'h1, 1);
		chk(program_counter_o, 15'h50ff);
		@(posedge clk_i);
		rel_offset_i <= 6'h00;
		go(3'h0, 3'h1, 1);
		chk(program_counter_o, 15'h5100);
		go(3'h0, 3'h2, 1);
		chk(program_counter_o, 15'h5123);
	endtask
	task automatic t_table();
		@(posedge clk_i);
		accumulator_i <= 8'h40;
		vector_addr_i <= 15'h2a10;
		go(3'h6, 3'h0, 1);
		chk({prog_req_o, prog_addr_o}, 16'hd140);
		@(posedge clk_i);
		#1;
		chk({prog_data_valid_o, prog_data_o}, 9'h14b);
		go(3'h0, 3'h4, 2);
		chk(program_counter_o, 15'h514b);
		go(3'h0, 3'h5, 1);
		chk(busy_o, 1'b1);
		// The long jump lands while busy and must be dropped
		go(3'h0, 3'h3, 2);
		chk({busy_o, program_counter_o}, 16'h6061);
	endtask
	initial
	begin
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		t_state();
		t_operand();
		t_jump();
		t_table();
		end_sim();
	end
endmodule
bind oabag_top oabag_monitor u_mon (.*);
`default_nettype wire
